//--- measurement_averaging_filter.sv
// measurement filter chain: hold, spike, difference, averaging, statistics
// assumes upstream distance logic on the same clock; config pulses are one cycle
//
// Summary of operation
// - video lines averaged pixel by pixel
// - alternating exposure bypasses video averaging
// - averaging follows results, precedes outputs
// - one filtered value per measuring cycle
// - defaults: moving average, window one
// - moving mode outputs mean of N
// - newest enters window, oldest leaves
// - moving window power of two, max 1024
// - recursive: (new plus (N-1)prev)/N, N<=32768
// - median: sort window, output middle element
// - median window three, five, seven, nine
// - default: hold count zero, so error flag only before the first valid reading
// - hold last valid for count cycles
// - hold count zero holds indefinitely
// - spike reference is mean of previous values
// - outside tolerance: replace with previous value
// - consecutive outliers use corrected value, limited
// - evaluation length ten, corrections hundred maximum
// - same correction each channel; difference after
// - spike correction precedes averaging
// - min, max, peak-to-peak over evaluation cycle
// - statistics reset clears and restarts cycle
// - fixed processing order through the chain
`timescale 1ns/100ps
`include "filt_consts.svh"
module measurement_averaging_filter
  import filt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic [1:0]        vid_mode,
  input  wire logic              alt_exp,
  input  wire logic              pix_valid,
  input  wire logic [`PIX_AW-1:0] pix_idx,
  input  wire logic [`PIX_DW-1:0] pix_in,
  output logic                   pix_out_valid,
  output logic [`PIX_DW-1:0]     pix_out,
  input  wire logic              cfg_load,
  input  wire logic              cfg_default,
  input  wire logic [1:0]        cfg_mode,
  input  wire logic [3:0]        cfg_mov_log,
  input  wire logic [15:0]       cfg_rec_n,
  input  wire logic [3:0]        cfg_med_n,
  input  wire logic [10:0]       cfg_hold_n,
  input  wire logic              cfg_spk_en,
  input  wire logic [3:0]        cfg_spk_len,
  input  wire logic [15:0]       cfg_spk_tol,
  input  wire logic [6:0]        cfg_spk_max,
  input  wire logic [3:0]        cfg_stat_log,
  input  wire logic [1:0]        cfg_sel,
  input  wire logic              stat_clr,
  input  wire logic              meas_valid,
  output logic                   meas_ready,
  input  wire val_t              dist0,
  input  wire val_t              dist1,
  input  wire logic              ok0,
  input  wire logic              ok1,
  output logic                   res_valid,
  input  wire logic              res_ready,
  output val_t                   res_val,
  output logic                   res_err,
  output val_t                   stat_min,
  output val_t                   stat_max,
  output val_t                   stat_pp,
  output logic                   stat_valid
);
  function automatic logic [16:0] recip(input logic [3:0] n);
    recip = (n == 4'h0) ? 17'h0 : 17'((32'h10000 + 32'(n >> 1)) / 32'(n));
  endfunction : recip

  ////////////////////////////////////////////////////////////////////////////
  // video stage, ahead of distance computation
  video_line_avg u_video (
    .clock         (clock),
    .arst_n        (arst_n),
    .vid_mode      (vid_mode),
    .alt_exp       (alt_exp),
    .pix_valid     (pix_valid),
    .pix_idx       (pix_idx),
    .pix_in        (pix_in),
    .pix_out_valid (pix_out_valid),
    .pix_out       (pix_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration, clamped to legal ranges on load
  avg_mode_t   mode_r;
  logic [3:0]  mov_log_r;
  logic [15:0] rec_n_r;
  logic [3:0]  med_n_r;
  logic [10:0] hold_n_r;
  logic        spk_en_r;
  logic [3:0]  spk_len_r;
  logic [15:0] spk_tol_r;
  logic [6:0]  spk_max_r;
  logic [3:0]  stat_log_r;
  logic [1:0]  sel_r;
  logic        cfg_chg;
  logic [3:0]  med_odd;

  assign cfg_chg = cfg_load || cfg_default;
  assign med_odd = cfg_med_n | 4'h1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n || cfg_default) begin
      mode_r     <= AVG_MOV;
      mov_log_r  <= `MOV_LOG_RST;
      rec_n_r    <= `REC_N_RST;
      med_n_r    <= `MED_N_RST;
      hold_n_r   <= `HOLD_N_RST;
      spk_en_r   <= 1'b0;
      spk_len_r  <= `SPK_LEN_RST;
      spk_tol_r  <= `SPK_TOL_RST;
      spk_max_r  <= `SPK_CNT_RST;
      stat_log_r <= `STAT_LOG_RST;
      sel_r      <= `SEL_RST;
    end else if (cfg_load) begin
      mode_r     <= (cfg_mode == 2'b11) ? AVG_MOV : avg_mode_t'(cfg_mode);
      mov_log_r  <= (cfg_mov_log > `MOV_LOG_MAX) ? `MOV_LOG_MAX : cfg_mov_log;
      rec_n_r    <= (cfg_rec_n == 16'h0) ? 16'h0001 :
                    (cfg_rec_n > `REC_MAX) ? `REC_MAX : cfg_rec_n;
      med_n_r    <= (med_odd < `MED_MIN_N) ? `MED_MIN_N :
                    (med_odd > `MED_MAX_N) ? `MED_MAX_N : med_odd;
      hold_n_r   <= (cfg_hold_n > `HOLD_MAX) ? `HOLD_MAX : cfg_hold_n;
      spk_en_r   <= cfg_spk_en;
      spk_len_r  <= (cfg_spk_len == 4'h0) ? 4'h1 :
                    (cfg_spk_len > `SPK_LEN_MAX) ? `SPK_LEN_MAX : cfg_spk_len;
      spk_tol_r  <= cfg_spk_tol;
      spk_max_r  <= (cfg_spk_max == 7'h0) ? 7'h01 :
                    (cfg_spk_max > `CORR_MAX) ? `CORR_MAX : cfg_spk_max;
      stat_log_r <= (cfg_stat_log > `STAT_LOG_MAX) ? `STAT_LOG_MAX : cfg_stat_log;
      sel_r      <= (cfg_sel == 2'h3) ? 2'h0 : cfg_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: take, filter per channel, average, hand to buffer
  step_t      step_r;
  val_t       raw_r [2];
  logic [1:0] ok_r;
  logic       buf_ready;

  assign meas_ready = step_r == ST_IDLE;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_r   <= ST_IDLE;
      raw_r[0] <= '0;
      raw_r[1] <= '0;
      ok_r     <= 2'h0;
    end else begin
      case (step_r)
        ST_IDLE: begin
          if (meas_valid) begin
            raw_r[0] <= dist0;
            raw_r[1] <= dist1;
            ok_r     <= {ok1, ok0};
            step_r   <= ST_FILT;
          end
        end
        ST_FILT: step_r <= ST_AVG;
        ST_AVG:  step_r <= ST_PUSH;
        ST_PUSH: begin
          // a full buffer stalls here, and meas_ready stays low
          if (buf_ready) begin
            step_r <= ST_IDLE;
          end
        end
        default: step_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel: hold last value, then spike correction
  wire sample_t ch_v [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    val_t              last_r;
    val_t              prev_r;
    val_t              hist_r [`SPK_MAX];
    logic              have_r;
    logic [10:0]       hcnt_r;
    logic [3:0]        fill_r;
    logic [6:0]        run_r;
    sample_t           q_r;
    val_t              hv;
    val_t              sv;
    logic              he;
    logic              spike;
    logic [3:0]        n;
    logic signed [`DW+3:0]  sum;
    logic signed [`DW+21:0] prod;
    logic signed [`DW:0]    dev;
    logic [`DW:0]      mag;

    always_comb begin
      n   = (fill_r < spk_len_r) ? fill_r : spk_len_r;
      sum = '0;
      for (int i = 0; i < `SPK_MAX; i++) begin
        if (i < int'(n)) begin
          sum = sum + (`DW+4)'(hist_r[i]);
        end
      end
      prod = sum * $signed({1'b0, recip(n)});
      dev  = (`DW+1)'(raw_r[c]) - (`DW+1)'(prod >>> 16);
      mag  = dev[`DW] ? (`DW+1)'(-dev) : (`DW+1)'(dev);
      he   = 1'b0;
      hv   = raw_r[c];
      if (!ok_r[c]) begin
        hv = last_r;
        he = !(have_r && (hold_n_r == 11'h0 || hcnt_r < hold_n_r));
      end
      spike = spk_en_r && ok_r[c] && n != 4'h0 && run_r < spk_max_r
              && mag > {1'b0, spk_tol_r};
      sv    = spike ? prev_r : hv;
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        last_r <= '0;
        prev_r <= '0;
        have_r <= 1'b0;
        hcnt_r <= 11'h0;
        fill_r <= 4'h0;
        run_r  <= 7'h0;
        q_r    <= '0;
        for (int i = 0; i < `SPK_MAX; i++) begin
          hist_r[i] <= '0;
        end
      end else if (step_r == ST_FILT) begin
        q_r <= '{err: he, val: he ? val_t'(0) : sv};
        if (ok_r[c]) begin
          last_r <= raw_r[c];
          have_r <= 1'b1;
          hcnt_r <= 11'h0;
          hist_r[0] <= sv;
          for (int i = 1; i < `SPK_MAX; i++) begin
            hist_r[i] <= hist_r[i-1];
          end
          fill_r <= (fill_r == `SPK_LEN_MAX) ? fill_r : fill_r + 4'h1;
          run_r  <= spike ? run_r + 7'h1 : 7'h0;
        end else if (!he && hcnt_r != 11'h7ff) begin
          hcnt_r <= hcnt_r + 11'h1;
        end
        if (!he) begin
          prev_r <= sv;
        end
      end
    end

    assign ch_v[c] = q_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // difference from corrected distances, then signal selection
  val_t x;
  logic xe;

  always_comb begin
    x  = ch_v[0].val;
    xe = ch_v[0].err;
    if (sel_r == 2'h1) begin
      x  = ch_v[1].val;
      xe = ch_v[1].err;
    end else if (sel_r == 2'h2) begin
      x  = ch_v[1].val - ch_v[0].val;
      xe = ch_v[0].err || ch_v[1].err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // moving, recursive and median averaging on the selected result
  val_t                   mov_mem [`MOV_DEPTH];
  logic [10:0]            mov_n;
  logic [10:0]            mov_cnt_r;
  logic [10:0]            mov_cnt_nxt;
  logic [9:0]             mov_ptr_r;
  logic [9:0]             mov_ptr_nxt;
  logic signed [`DW+10:0] mov_sum_r;
  logic signed [`DW+10:0] mov_sum_nxt;
  logic                   mov_full;
  logic signed [`DW+15:0] rec_acc_r;
  logic signed [`DW+15:0] rec_acc_nxt;
  logic signed [`DW+16:0] rec_d;
  logic                   rec_init_r;
  val_t                   med_r  [`MED_MAX];
  val_t                   med_nx [`MED_MAX];
  logic [3:0]             med_cnt_r;
  logic [3:0]             med_k;
  logic [3:0]             med_mid;
  logic [`MED_MAX-1:0]    med_hit;
  val_t                   mov_y;
  val_t                   rec_y;
  val_t                   med_y;
  val_t                   avg_y;

  always_comb begin
    mov_n       = 11'h1 << mov_log_r;
    mov_full    = mov_cnt_r == mov_n;
    mov_sum_nxt = mov_sum_r + (`DW+11)'(x)
                  - (mov_full ? (`DW+11)'(mov_mem[mov_ptr_r]) : (`DW+11)'(0));
    mov_cnt_nxt = mov_full ? mov_cnt_r : mov_cnt_r + 11'h1;
    mov_ptr_nxt = (mov_ptr_r + 10'h1) & 10'(mov_n - 11'h1);
    mov_y       = val_t'(mov_sum_nxt / $signed({1'b0, mov_cnt_nxt}));
    rec_d       = (`DW+17)'($signed({x, 16'h0})) - (`DW+17)'(rec_acc_r);
    rec_acc_nxt = rec_init_r ? (`DW+16)'($signed({x, 16'h0})) :
                  rec_acc_r + (`DW+16)'(rec_d / $signed({1'b0, rec_n_r}));
    rec_y       = rec_acc_nxt[`DW+15:16];
    med_nx[0]   = x;
    for (int i = 1; i < `MED_MAX; i++) begin
      med_nx[i] = med_r[i-1];
    end
    med_k   = (med_cnt_r < med_n_r) ? med_cnt_r + 4'h1 : med_n_r;
    med_mid = (med_k - 4'h1) >> 1;
    med_y   = x;
    for (int i = 0; i < `MED_MAX; i++) begin
      if (med_hit[i]) begin
        med_y = med_nx[i];
      end
    end
    avg_y = (mode_r == AVG_REC) ? rec_y : (mode_r == AVG_MED) ? med_y : mov_y;
  end

  // rank of each entry in the window; ties broken by age
  for (genvar i = 0; i < `MED_MAX; i++) begin : g_rank
    logic [3:0] r;
    always_comb begin
      r = 4'h0;
      for (int j = 0; j < `MED_MAX; j++) begin
        if (j < int'(med_k) && (med_nx[j] < med_nx[i] || (med_nx[j] == med_nx[i] && j < i))) begin
          r = r + 4'h1;
        end
      end
    end
    assign med_hit[i] = (i < int'(med_k)) && r == med_mid;
  end

  // window memory has no reset; fill counters guard stale words
  always_ff @(posedge clock) begin
    if (step_r == ST_AVG && !xe) begin
      mov_mem[mov_ptr_r] <= x;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mov_cnt_r  <= 11'h0;
      mov_ptr_r  <= 10'h0;
      mov_sum_r  <= '0;
      rec_acc_r  <= '0;
      rec_init_r <= 1'b1;
      med_cnt_r  <= 4'h0;
      for (int i = 0; i < `MED_MAX; i++) begin
        med_r[i] <= '0;
      end
    end else if (cfg_chg) begin
      mov_cnt_r  <= 11'h0;
      mov_ptr_r  <= 10'h0;
      mov_sum_r  <= '0;
      rec_init_r <= 1'b1;
      med_cnt_r  <= 4'h0;
    end else if (step_r == ST_AVG && !xe) begin
      mov_cnt_r  <= mov_cnt_nxt;
      mov_ptr_r  <= mov_ptr_nxt;
      mov_sum_r  <= mov_sum_nxt;
      rec_acc_r  <= rec_acc_nxt;
      rec_init_r <= 1'b0;
      med_cnt_r  <= med_k;
      for (int i = 0; i < `MED_MAX; i++) begin
        med_r[i] <= med_nx[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result register and statistics
  sample_t     res_r;
  logic [14:0] stat_cnt_r;
  logic        fresh_r;
  logic        restart;
  val_t        mn_nxt;
  val_t        mx_nxt;

  always_comb begin
    restart = fresh_r || stat_clr ||
              (stat_log_r != 4'h0 && stat_cnt_r == (15'h1 << stat_log_r));
    mn_nxt  = (restart || avg_y < stat_min) ? avg_y : stat_min;
    mx_nxt  = (restart || avg_y > stat_max) ? avg_y : stat_max;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      res_r <= '0;
    end else if (step_r == ST_AVG) begin
      res_r <= '{err: xe, val: xe ? val_t'(0) : avg_y};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat_min   <= '0;
      stat_max   <= '0;
      stat_pp    <= '0;
      stat_cnt_r <= 15'h0;
      fresh_r    <= 1'b1;
      stat_valid <= 1'b0;
    end else begin
      if (stat_clr) begin
        stat_min   <= '0;
        stat_max   <= '0;
        stat_pp    <= '0;
        stat_cnt_r <= 15'h0;
        fresh_r    <= 1'b1;
        stat_valid <= 1'b0;
      end
      // a sample in the clearing cycle opens the new cycle
      if (step_r == ST_AVG && !xe) begin
        stat_min   <= mn_nxt;
        stat_max   <= mx_nxt;
        stat_pp    <= mx_nxt - mn_nxt;
        stat_cnt_r <= restart ? 15'h1 :
                      (stat_cnt_r == 15'h7fff) ? stat_cnt_r : stat_cnt_r + 15'h1;
        fresh_r    <= 1'b0;
        stat_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer: receiver stall holds the chain in ST_PUSH
  sample_t out_s;

  two_entry_buffer u_buf (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (step_r == ST_PUSH),
    .in_ready  (buf_ready),
    .in_data   (res_r),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (out_s)
  );

  assign res_val = out_s.val;
  assign res_err = out_s.err;
endmodule : measurement_averaging_filter

//--- filt_consts.svh
// constants for the measurement filter chain
// assumes inclusion by filt_pkg, the design modules and the bench top
`ifndef FILT_CONSTS_SVH
`define FILT_CONSTS_SVH
`define DW          16
`define MOV_DEPTH   1024
`define MOV_LOG_MAX 4'ha
`define MED_MAX     9
`define MED_MIN_N   4'h3
`define MED_MAX_N   4'h9
`define SPK_MAX     10
`define SPK_LEN_MAX 4'ha
`define CORR_MAX    7'h64
`define HOLD_MAX    11'h400
`define REC_MAX     16'h8000
`define STAT_LOG_MAX 4'he
`define PIX_DEPTH   512
`define PIX_AW      9
`define PIX_DW      12
`define MOV_LOG_RST 4'h0
`define REC_N_RST   16'h0001
`define MED_N_RST   4'h3
`define HOLD_N_RST  11'h000
`define SPK_LEN_RST 4'h1
`define SPK_TOL_RST 16'h0000
`define SPK_CNT_RST 7'h01
`define STAT_LOG_RST 4'h0
`define SEL_RST     2'h0
`endif

//--- filt_pkg.sv
// shared types of the measurement filter chain
// assumes filt_consts.svh in the include path
`include "filt_consts.svh"
package filt_pkg;
  typedef enum logic [1:0] {AVG_MOV = 2'b00, AVG_REC = 2'b01, AVG_MED = 2'b10} avg_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FILT = 2'b01,
                            ST_AVG = 2'b10, ST_PUSH = 2'b11} step_t;
  typedef logic signed [`DW-1:0] val_t;
  typedef struct packed {
    logic err;
    val_t val;
  } sample_t;
endpackage : filt_pkg

//--- two_entry_buffer.sv
// two-entry result buffer with valid/ready on both sides
// assumes one clock domain shared with producer and consumer
`timescale 1ns/100ps
module two_entry_buffer
  import filt_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    arst_n,
  input  wire logic    in_valid,
  output logic         in_ready,
  input  wire sample_t in_data,
  output logic         out_valid,
  input  wire logic    out_ready,
  output sample_t      out_data
);
  sample_t    slot_r [2];
  logic [1:0] cnt_r;
  logic       rd_r;
  logic       wr_r;
  logic       push;
  logic       pop;

  assign in_ready  = cnt_r != 2'h2;
  assign out_valid = cnt_r != 2'h0;
  assign out_data  = slot_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= 2'h0;
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      if (push) begin
        slot_r[wr_r] <= in_data;
        wr_r         <= !wr_r;
      end
      if (pop) begin
        rd_r <= !rd_r;
      end
      cnt_r <= cnt_r + 2'(push) - 2'(pop);
    end
  end
endmodule : two_entry_buffer

//--- video_line_avg.sv
// pixel-by-pixel recursive averaging of successive video lines
// assumes pixels arrive with their line position, one per valid
`timescale 1ns/100ps
`include "filt_consts.svh"
module video_line_avg
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic [1:0]        vid_mode,
  input  wire logic              alt_exp,
  input  wire logic              pix_valid,
  input  wire logic [`PIX_AW-1:0] pix_idx,
  input  wire logic [`PIX_DW-1:0] pix_in,
  output logic                   pix_out_valid,
  output logic [`PIX_DW-1:0]     pix_out
);
  logic [`PIX_DW-1:0]   line_r [`PIX_DEPTH];
  logic [1:0]           eff;
  logic [1:0]           eff_r;
  logic                 first_r;
  logic signed [`PIX_DW+1:0] d;
  logic [`PIX_DW-1:0]   avg;

  assign eff = alt_exp ? 2'h0 : vid_mode;

  always_comb begin
    d   = $signed({2'b00, pix_in}) - $signed({2'b00, line_r[pix_idx]});
    avg = `PIX_DW'($signed({2'b00, line_r[pix_idx]}) + (d >>> eff));
  end

  // no reset: line memory is seeded by the first line after a mode change
  always_ff @(posedge clock) begin
    if (pix_valid) begin
      line_r[pix_idx] <= (eff == 2'h0 || first_r) ? pix_in : avg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pix_out_valid <= 1'b0;
      pix_out       <= '0;
      eff_r         <= 2'h0;
      first_r       <= 1'b1;
    end else begin
      pix_out_valid <= pix_valid;
      if (pix_valid) begin
        pix_out <= (eff == 2'h0 || first_r) ? pix_in : avg;
      end
      eff_r <= eff;
      if (eff != eff_r) begin
        first_r <= 1'b1;
      end else if (pix_valid && pix_idx == `PIX_AW'(`PIX_DEPTH - 1)) begin
        first_r <= 1'b0;
      end
    end
  end
endmodule : video_line_avg

//--- maf_monitor.sv
// checker for the filter chain ports
// assumes bind onto measurement_averaging_filter, one clock domain
`timescale 1ns/100ps
module maf_monitor
  import filt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pix_valid,
  input wire logic pix_out_valid,
  input wire logic stat_clr,
  input wire logic meas_valid,
  input wire logic meas_ready,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire val_t res_val,
  input wire logic res_err,
  input wire val_t stat_min,
  input wire val_t stat_max,
  input wire val_t stat_pp,
  input wire logic stat_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_take; meas_valid && meas_ready; endsequence
  sequence s_busy; !meas_ready [*3]; endsequence
  a_pix_echo: assert property (pix_valid |=> pix_out_valid)
    else $error("pixel not echoed");
  a_pix_pulse: assert property (!pix_valid |=> !pix_out_valid)
    else $error("stray pixel strobe");
  a_busy_gap: assert property (s_take |=> s_busy)
    else $error("chain took early");
  a_result_due: assert property (s_take ##0 !res_valid |-> ##4 res_valid)
    else $error("result late");
  a_err_zero: assert property (res_valid && res_err |-> res_val == '0)
    else $error("error word not zero");
  a_word_holds: assert property (res_valid && !res_ready |=>
    res_valid && $stable(res_val) && $stable(res_err)) else $error("word lost");
  // a sample in the same cycle would start the new cycle, so skip it
  a_stat_clear: assert property (stat_clr && !$past(meas_valid && meas_ready, 2)
    |=> !stat_valid) else $error("stats not cleared");
  a_pp_span: assert property (stat_valid |-> stat_pp == val_t'(stat_max - stat_min))
    else $error("peak to peak wrong");
  a_min_max: assert property (stat_valid |-> stat_min <= stat_max)
    else $error("min above max");
endmodule : maf_monitor
bind measurement_averaging_filter maf_monitor i_maf_monitor (.clock, .arst_n, .pix_valid,
  .pix_out_valid, .stat_clr, .meas_valid, .meas_ready, .res_valid, .res_ready, .res_val,
  .res_err, .stat_min, .stat_max, .stat_pp, .stat_valid);

//--- result_sink.sv
// downstream consumer model for filter results
// assumes the bench drives stall; words kept in arrival order
`timescale 1ns/100ps
module result_sink
  import filt_pkg::*;
(
  input  wire logic clock,
  input  wire logic stall,
  input  wire logic res_valid,
  input  wire val_t res_val,
  input  wire logic res_err,
  output logic      res_ready
);
  sample_t got[$];
  initial res_ready = 1'b0;
  // ready moves off the sampling edge only
  always @(negedge clock) res_ready <= !stall;
  // word and error flag taken together where ready meets valid
  always @(posedge clock) if (res_valid && res_ready) got.push_back({res_err, res_val});
endmodule : result_sink

//--- measurement_averaging_filter_tb_top.sv
// self-checking bench for the filter chain
// assumes filt_pkg compiled first; inputs change at the falling edge
`timescale 1ns/100ps
`include "filt_consts.svh"
module measurement_averaging_filter_tb_top
  import filt_pkg::*;
;
  logic clock, arst_n, alt_exp, pix_valid, cfg_load, cfg_default, cfg_spk_en, stat_clr;
  logic meas_valid, ok0, ok1, stall, pix_out_valid, meas_ready, res_valid, res_ready;
  logic res_err, stat_valid;
  logic [1:0]         vid_mode, cfg_mode, cfg_sel;
  logic [3:0]         cfg_mov_log, cfg_med_n, cfg_spk_len, cfg_stat_log;
  logic [`PIX_AW-1:0] pix_idx;
  logic [`PIX_DW-1:0] pix_in, pix_out;
  logic [15:0]        cfg_rec_n, cfg_spk_tol;
  logic [10:0]        cfg_hold_n;
  logic [6:0]         cfg_spk_max;
  val_t               dist0, dist1, res_val, stat_min, stat_max, stat_pp;
  int                 fail_count, compares;
  measurement_averaging_filter i_measurement_averaging_filter (.clock, .arst_n, .vid_mode,
    .alt_exp, .pix_valid, .pix_idx, .pix_in, .pix_out_valid, .pix_out, .cfg_load,
    .cfg_default, .cfg_mode, .cfg_mov_log, .cfg_rec_n, .cfg_med_n, .cfg_hold_n, .cfg_spk_en,
    .cfg_spk_len, .cfg_spk_tol, .cfg_spk_max, .cfg_stat_log, .cfg_sel, .stat_clr,
    .meas_valid, .meas_ready, .dist0, .dist1, .ok0, .ok1, .res_valid, .res_ready, .res_val,
    .res_err, .stat_min, .stat_max, .stat_pp, .stat_valid);
  result_sink i_result_sink (.clock, .stall, .res_valid, .res_val, .res_err, .res_ready);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // request held until an edge with ready high takes it
  task automatic send(input val_t a, input val_t b, input logic g0, input logic g1);
    @(negedge clock);
    {dist0, dist1, ok0, ok1, meas_valid} = {a, b, g0, g1, 1'b1};
    for (int i = 0; i < 200 && meas_ready !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    meas_valid = 1'b0;
  endtask : send
  task automatic expect_word(input logic [16:0] exp);
    for (int i = 0; i < 200 && i_result_sink.got.size() == 0; i++) @(posedge clock);
    check(i_result_sink.got.pop_front(), exp);
    @(negedge clock);
  endtask : expect_word
  task automatic pulse(input int which);
    @(negedge clock);
    {cfg_load, cfg_default, stat_clr} = 3'b100 >> which;
    @(negedge clock);
    {cfg_load, cfg_default, stat_clr} = 3'b000;
  endtask : pulse
  task automatic run(input val_t i[6], input val_t e[6]);
    foreach (i[k]) begin
      send(i[k], '0, 1'b1, 1'b1);
      expect_word({1'b0, e[k]});
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, alt_exp, pix_valid, cfg_load, cfg_default, cfg_spk_en, stat_clr} = '0;
    {meas_valid, ok0, ok1, stall, vid_mode, cfg_mode, cfg_sel, pix_idx, pix_in} = '0;
    {cfg_mov_log, cfg_med_n, cfg_spk_len, cfg_stat_log, cfg_rec_n, cfg_spk_tol} = '0;
    {cfg_hold_n, cfg_spk_max, dist0, dist1, fail_count, compares} = '0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    // consumer stalls: two words buffered, third waits in the chain
    stall = 1'b1;
    for (int k = 5; k < 8; k++) send(val_t'(k), '0, 1'b1, 1'b1);
    repeat (4) @(negedge clock);
    check({16'h0, meas_ready}, 17'h0);
    check({1'b0, res_val}, 17'h5);
    stall = 1'b0;
    for (int k = 5; k < 8; k++) expect_word(17'(k));
    {cfg_mov_log, cfg_rec_n, cfg_med_n} = {4'h2, 16'h2, 4'h5};
    pulse(0);
    run('{4, 8, 12, 16, 20, 20}, '{4, 6, 8, 10, 14, 17});
    cfg_mode = 2'h1;
    pulse(0);
    run('{10, 20, 5, 5, 5, 5}, '{10, 15, 10, 7, 6, 5});
    cfg_mode = 2'h2;
    pulse(0);
    run('{2, 4, 5, 1, 3, 5}, '{2, 2, 4, 2, 3, 4});
    {cfg_mode, cfg_mov_log, cfg_spk_en, cfg_spk_len, cfg_spk_tol, cfg_spk_max} =
      {2'h0, 4'h0, 1'b1, 4'h3, 16'h5, 7'h1};
    pulse(0);
    // spike history still holds 5, 3, 1 from the median run, so the first 10 is an outlier
    run('{10, 10, 10, 40, 40, 40}, '{5, 10, 10, 10, 40, 40});
    {cfg_spk_en, cfg_hold_n} = {1'b0, 11'h2};
    pulse(0);
    send(16'sh7, '0, 1'b1, 1'b1);
    expect_word(17'h7);
    for (int k = 0; k < 3; k++) send('0, '0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) expect_word(17'h7);
    expect_word(17'h10000);
    cfg_hold_n = 11'h0;
    pulse(0);
    send(16'sh9, '0, 1'b1, 1'b1);
    for (int k = 0; k < 3; k++) send('0, '0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) expect_word(17'h9);
    cfg_sel = 2'h2;
    pulse(0);
    send(16'sh3, 16'sha, 1'b1, 1'b1);
    expect_word(17'h7);
    {cfg_sel, cfg_mov_log} = {2'h0, 4'h3};
    pulse(1);
    pulse(2);
    send(16'sh3, '0, 1'b1, 1'b1);
    expect_word(17'h3);
    send(16'sh9, '0, 1'b1, 1'b1);
    expect_word(17'h9);
    check({1'b0, stat_min}, 17'h3);
    check({1'b0, stat_max}, 17'h9);
    check({1'b0, stat_pp}, 17'h6);
    pulse(2);
    check({16'h0, stat_valid}, 17'h0);
    // first line seeds the line memory; pixel 0 of the next line is averaged by half
    {vid_mode, pix_valid} = {2'h1, 1'b1};
    for (int k = 0; k < 513; k++) begin
      pix_idx = `PIX_AW'(k);
      pix_in  = k[9] ? 12'h200 : 12'h100;
      @(negedge clock);
    end
    check({5'h0, pix_out}, 17'h180);
    {alt_exp, pix_idx} = {1'b1, 9'h1};
    @(negedge clock);
    pix_valid = 1'b0;
    check({16'h0, pix_out_valid}, 17'h1);
    check({5'h0, pix_out}, 17'h200);
    tally_and_finish();
  end
  // whole run needs under a thousand cycles
  initial begin
    #(20 * 20000);
    fail_count++;
    tally_and_finish();
  end
endmodule : measurement_averaging_filter_tb_top
